// *** shared/spu_defs.svh ***
// Purpose: constants of the serial peripheral unit
// Assumes: included by the package and the design file
// Notes: widths, lengths and codes are fixed
`ifndef SPU_DEFS_SVH
`define SPU_DEFS_SVH

// ==========================================================
// widths and depths
`define SPU_W 32
`define SPU_DEPTH 8
`define SPU_NCMD 8
`define SPU_NSEL 4
`define SPU_DIV_W 11
`define SPU_DLY_W 3

// ==========================================================
// frame length codes: 0..8 give 8..16 bits, then 20, 24, 32
`define SPU_LEN_BASE 6'h08
`define SPU_LCODE_LIN 4'h8
`define SPU_LCODE_20 4'h9
`define SPU_LCODE_24 4'hA
`define SPU_LEN_20 6'h14
`define SPU_LEN_24 6'h18
`define SPU_LEN_32 6'h20

// ==========================================================
// reset values
`define SPU_IDX_RST 3'h0
`define SPU_ECNT_RST 7'h00
`define SPU_WORD_RST 32'h0000_0000

`endif

// *** shared/spu_pkg.sv ***
// Purpose: types of the serial peripheral unit
// Assumes: spu_defs.svh supplies the widths
// Notes: command and configuration travel as packed structs
`include "spu_defs.svh"

package spu_pkg;

    // ======================================================
    // modes and states
    typedef enum logic [1:0] {
        SPU_SINGLE = 2'h0,
        SPU_MULTI = 2'h1,
        SPU_SLAVE = 2'h2
    } spu_mode_t;

    typedef enum logic [2:0] {
        SPU_S_IDLE = 3'h0,
        SPU_S_LEAD = 3'h1,
        SPU_S_SHIFT = 3'h3,
        SPU_S_NEG = 3'h2,
        SPU_S_NEXT = 3'h6
    } spu_state_t;

    // ======================================================
    // one sequencer command
    typedef struct packed {
        logic [1:0] sel;
        logic [`SPU_DIV_W-1:0] brdiv;
        logic cpol;
        logic cpha;
        logic [3:0] len_code;
        logic lsb_first;
        logic burst;
        logic [`SPU_DLY_W-1:0] ck_dly;
        logic [`SPU_DLY_W-1:0] neg_dly;
        logic [`SPU_DLY_W-1:0] nxt_dly;
    } spu_cmd_t;

    // ======================================================
    // static configuration
    typedef struct packed {
        logic enable;
        spu_mode_t mode;
        logic three_wire;
        logic tx_only;
        logic [`SPU_NSEL-1:0] sel_pol;
        logic idle_mosi;
        logic clock_auto_stop_enable;
        logic par_en;
        logic par_odd;
        logic [2:0] seq_last;
        logic [3:0] irq_en;
    } spu_cfg_t;

    typedef struct packed {
        logic modf;
        logic ovr;
        logic par;
    } spu_err_t;

endpackage

// *** core/spu_core.sv ***
// Purpose: SPI master/slave unit with command sequencer
// Assumes: 50 MHz clk, pins synchronised here
// Notes: tx path buffered by an 8 word FIFO
`timescale 1ns/1ps
`include "spu_defs.svh"

// ==========================================================
// transmit FIFO
module spu_fifo #(
    parameter int W = `SPU_W,
    parameter int DEPTH = `SPU_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // fill side
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // drain side
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q];
    assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_q <= AW'(wr_q + 1'b1);
            end
            if (pop) begin
                rd_q <= AW'(rd_q + 1'b1);
            end
            cnt_q <= cnt_d;
            // ready stays a flop so back-pressure is registered
            in_ready <= (cnt_d != (AW+1)'(DEPTH));
            out_valid <= (cnt_d != '0);
        end
    end
endmodule

// ==========================================================
// unit top
module spu_core
    import spu_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // configuration
    input wire spu_cfg_t cfg,
    input wire logic cmd_we,
    input wire logic [2:0] cmd_sel,
    input wire spu_cmd_t cmd_wdata,
    input wire logic [2:0] err_clr,
    // transmit stream
    input wire logic [`SPU_W-1:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    // receive store
    output logic [`SPU_W-1:0] rx_data_q,
    output logic rx_buffer_full_flag,
    input wire logic rx_ack,
    // serial pins
    input wire logic serial_clock_line_i,
    output logic serial_clock_line_o,
    output logic serial_clock_line_oe,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe,
    input wire logic select_line_zero_i,
    output logic [`SPU_NSEL-1:0] slave_select_line_o,
    output logic [`SPU_NSEL-1:0] slave_select_line_oe,
    // status
    output logic tx_buffer_empty_flag,
    output spu_err_t err_q,
    output logic idle_q,
    // interrupts and events
    output logic [3:0] irq_q,
    output logic [4:0] ev_q
);
    // ======================================================
    // helpers
    function automatic logic [5:0] len_of(input logic [3:0] c);
        if (c <= `SPU_LCODE_LIN) begin
            len_of = `SPU_LEN_BASE + 6'(c);
        end else if (c == `SPU_LCODE_20) begin
            len_of = `SPU_LEN_20;
        end else if (c == `SPU_LCODE_24) begin
            len_of = `SPU_LEN_24;
        end else begin
            len_of = `SPU_LEN_32;
        end
    endfunction

    function automatic logic [31:0] mask_of(input logic [5:0] n);
        mask_of = ~(32'hFFFF_FFFF << n);
        if (n == `SPU_LEN_32) begin
            mask_of = 32'hFFFF_FFFF;
        end
    endfunction

    function automatic logic [31:0] prep(input logic [31:0] d,
            input logic [5:0] n, input logic lsb, input logic pe,
            input logic odd);
        logic [31:0] r;
        logic [4:0] pos;
        r = d & mask_of(n);
        pos = lsb ? 5'(n - 6'h01) : 5'h00;
        if (pe) begin
            r[pos] = 1'b0;
            r[pos] = (^r) ^ odd;
        end
        prep = r;
    endfunction

    // ======================================================
    // storage, FIFO and synchronisers
    spu_cmd_t cmd_q [`SPU_NCMD];
    spu_cmd_t cur;
    spu_state_t state_q;
    logic [2:0] idx_q;
    logic [`SPU_DIV_W-1:0] half_q;
    logic [3:0] dly_q;
    logic [`SPU_DLY_W-1:0] nxt_q;
    logic [6:0] ecnt_q;
    logic [5:0] len_q;
    logic lsb_q;
    logic cpha_q;
    logic [31:0] sh_q;
    logic [31:0] rsh_q;
    logic [31:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    logic [2:0] sck_s;
    logic [1:0] ss_s;
    logic [1:0] mosi_s;
    logic [1:0] miso_s;
    logic sel_q;

    assign cur = cmd_q[idx_q];

    spu_fifo #(.W(`SPU_W), .DEPTH(`SPU_DEPTH)) u_txf (
        .clk(clk),
        .nrst(nrst),
        .in_data(tx_data),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    always_ff @(posedge clk) begin
        if (cmd_we) begin
            cmd_q[cmd_sel] <= cmd_wdata;
        end
    end

    // pins pass two flops, edges seen on 2nd/3rd
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sck_s <= '0;
            ss_s <= '0;
            mosi_s <= '0;
            miso_s <= '0;
        end else begin
            sck_s <= {sck_s[1:0], serial_clock_line_i};
            ss_s <= {ss_s[0], select_line_zero_i};
            mosi_s <= {mosi_s[0], mosi_i};
            miso_s <= {miso_s[0], miso_i};
        end
    end

    // ======================================================
    // event decode
    logic is_master;
    logic is_slave;
    logic ss_act;
    logic sel_now;
    logic hold;
    logic tick;
    logic edge_ev;
    logic last_e;
    logic lead;
    logic sample;
    logic advance;
    logic in_bit;
    logic frame_done;
    logic m_start;
    logic s_start;
    logic burst_go;
    logic modf_set;
    logic [31:0] rsh_d;
    logic [31:0] rx_src;
    logic [31:0] rx_word;

    assign is_master = cfg.enable && (cfg.mode != SPU_SLAVE) && !err_q.modf;
    assign is_slave = cfg.enable && (cfg.mode == SPU_SLAVE);
    assign ss_act = (ss_s[1] == cfg.sel_pol[0]);
    assign sel_now = is_slave && (cfg.three_wire || ss_act);
    // hold the clock while receive store is full, except a burst frame starting in the cycle it fills
    assign hold = cfg.clock_auto_stop_enable && !cfg.tx_only
        && rx_buffer_full_flag;
    // half period is brdiv+1 bus clocks
    assign tick = (half_q == '0);
    assign lead = (ecnt_q[0] == 1'b0);
    assign edge_ev = (is_master && state_q == SPU_S_SHIFT && tick)
        || (sel_q && sel_now && (sck_s[1] != sck_s[2]));
    assign last_e = (ecnt_q == 7'({len_q, 1'b0}) - 7'h01);
    assign sample = cpha_q ? !lead : lead;
    assign advance = cpha_q ? (lead && ecnt_q != '0)
        : (!lead && !last_e);
    assign in_bit = is_slave ? mosi_s[1] : miso_s[1];
    assign frame_done = edge_ev && last_e;
    assign m_start = is_master && state_q == SPU_S_IDLE
        && fifo_valid && !hold;
    assign burst_go = is_master && frame_done && cur.burst
        && fifo_valid && !hold;
    assign s_start = sel_now && (!sel_q || frame_done);
    assign fifo_pop = m_start || burst_go || (s_start && fifo_valid);
    // select zero asserted in multi-master mode, or slave deselected mid-frame
    assign modf_set = (cfg.enable && cfg.mode == SPU_MULTI && ss_act)
        || (sel_q && !sel_now && ecnt_q != '0 && is_slave);

    always_comb begin
        rsh_d = {rsh_q[30:0], in_bit};
        // leading-edge sampling took its last bit one edge earlier
        rx_src = sample ? rsh_d : rsh_q;
        rx_word = rx_src & mask_of(len_q);
        // first bit received is bit 0 when LSB-first
        if (lsb_q) begin
            for (int i = 0; i < `SPU_W; i++) begin
                rx_word[i] = (6'(i) < len_q) ? rx_src[5'(len_q - 6'(i)
                    - 6'h01)] : 1'b0;
            end
        end
    end

    // ======================================================
    // master sequencer
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_q <= SPU_S_IDLE;
            idx_q <= `SPU_IDX_RST;
            half_q <= '0;
            dly_q <= '0;
            nxt_q <= '0;
        end else if (!is_master) begin
            state_q <= SPU_S_IDLE;
            idx_q <= `SPU_IDX_RST;
        end else begin
            half_q <= tick ? cur.brdiv : half_q - 1'b1;
            unique case (state_q)
                SPU_S_IDLE: begin
                    if (m_start) begin
                        state_q <= SPU_S_LEAD;
                        half_q <= cur.brdiv;
                        dly_q <= {cur.ck_dly, 1'b1};
                    end
                end
                SPU_S_LEAD: begin
                    if (tick) begin
                        dly_q <= dly_q - 1'b1;
                        if (dly_q == '0) begin
                            state_q <= SPU_S_SHIFT;
                        end
                    end
                end
                SPU_S_SHIFT: begin
                    if (frame_done) begin
                        idx_q <= (idx_q == cfg.seq_last) ? `SPU_IDX_RST
                            : idx_q + 1'b1;
                        if (!burst_go) begin
                            state_q <= SPU_S_NEG;
                            dly_q <= {cur.neg_dly, 1'b1};
                            nxt_q <= cur.nxt_dly;
                        end
                    end
                end
                SPU_S_NEG: begin
                    if (tick) begin
                        dly_q <= dly_q - 1'b1;
                        if (dly_q == '0) begin
                            state_q <= SPU_S_NEXT;
                            dly_q <= {nxt_q, 1'b1};
                        end
                    end
                end
                SPU_S_NEXT: begin
                    if (tick) begin
                        dly_q <= dly_q - 1'b1;
                        if (dly_q == '0) begin
                            state_q <= SPU_S_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= SPU_S_IDLE;
                end
            endcase
        end
    end

    // ======================================================
    // shift datapath, shared by master and slave
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sh_q <= `SPU_WORD_RST;
            rsh_q <= `SPU_WORD_RST;
            ecnt_q <= `SPU_ECNT_RST;
            len_q <= `SPU_LEN_BASE;
            lsb_q <= 1'b0;
            cpha_q <= 1'b0;
            sel_q <= 1'b0;
        end else begin
            sel_q <= sel_now;
            if (m_start || burst_go || s_start) begin
                len_q <= len_of(cur.len_code);
                lsb_q <= cur.lsb_first;
                cpha_q <= cur.cpha;
                sh_q <= prep(fifo_valid ? fifo_data : `SPU_WORD_RST,
                    len_of(cur.len_code), cur.lsb_first, cfg.par_en,
                    cfg.par_odd);
                ecnt_q <= `SPU_ECNT_RST;
            end else if (edge_ev) begin
                ecnt_q <= ecnt_q + 1'b1;
                if (sample) begin
                    rsh_q <= rsh_d;
                end
                if (advance) begin
                    sh_q <= lsb_q ? sh_q >> 1 : sh_q << 1;
                end
            end else if (!sel_now && is_slave) begin
                ecnt_q <= `SPU_ECNT_RST;
            end
        end
    end

    // ======================================================
    // pins
    logic xfer;
    logic obit;
    assign xfer = state_q == SPU_S_LEAD || state_q == SPU_S_SHIFT
        || state_q == SPU_S_NEG;
    assign obit = lsb_q ? sh_q[0] : sh_q[5'(len_q - 6'h01)];

    always_ff @(posedge clk) begin
        if (!nrst) begin
            serial_clock_line_o <= 1'b0;
            serial_clock_line_oe <= 1'b0;
            mosi_o <= 1'b0;
            mosi_oe <= 1'b0;
            miso_o <= 1'b0;
            miso_oe <= 1'b0;
            slave_select_line_o <= '0;
            slave_select_line_oe <= '0;
        end else begin
            if (is_master && state_q == SPU_S_SHIFT && edge_ev) begin
                serial_clock_line_o <= !serial_clock_line_o;
            end else if (!(is_master && state_q == SPU_S_SHIFT)) begin
                serial_clock_line_o <= cur.cpol;
            end
            serial_clock_line_oe <= is_master;
            mosi_o <= xfer ? obit : cfg.idle_mosi;
            mosi_oe <= is_master;
            miso_o <= obit;
            miso_oe <= sel_now;
            for (int i = 0; i < `SPU_NSEL; i++) begin
                slave_select_line_o[i] <= (xfer && 2'(i) == cur.sel)
                    ? cfg.sel_pol[i] : !cfg.sel_pol[i];
                slave_select_line_oe[i] <= cfg.enable
                    && (cfg.mode == SPU_SINGLE
                    || (cfg.mode == SPU_MULTI && i != 0));
            end
        end
    end

    // ======================================================
    // receive store, errors, status
    logic ovr_set;
    logic par_set;
    logic rx_take;
    logic [3:0] flags;
    logic tx_empty_d;

    assign rx_take = frame_done && !cfg.tx_only;
    // a full store is kept, the new frame is lost
    assign ovr_set = rx_take && rx_buffer_full_flag && !rx_ack;
    assign par_set = rx_take && cfg.par_en
        && ((^rx_word) != cfg.par_odd);
    assign tx_empty_d = !fifo_valid;
    assign flags = {state_q == SPU_S_IDLE && !fifo_valid && !sel_now,
        err_q.modf || err_q.ovr || err_q.par,
        tx_empty_d, rx_buffer_full_flag};

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rx_data_q <= `SPU_WORD_RST;
            rx_buffer_full_flag <= 1'b0;
            err_q <= '0;
        end else begin
            // second stage of the receive store
            if (rx_take && !ovr_set) begin
                rx_data_q <= rx_word;
            end
            // set wins over the acknowledge
            rx_buffer_full_flag <= (rx_take && !ovr_set)
                || (rx_buffer_full_flag && !rx_ack);
            // sticky errors, set wins over clear
            err_q.modf <= modf_set || (err_q.modf && !err_clr[2]);
            err_q.ovr <= ovr_set || (err_q.ovr && !err_clr[1]);
            err_q.par <= par_set || (err_q.par && !err_clr[0]);
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            tx_buffer_empty_flag <= 1'b1;
            idle_q <= 1'b1;
            irq_q <= '0;
            ev_q <= '0;
        end else begin
            tx_buffer_empty_flag <= tx_empty_d;
            idle_q <= flags[3];
            // idle, error, tx empty, rx full
            irq_q <= flags & cfg.irq_en;
            ev_q[0] <= rx_take && !ovr_set;
            ev_q[1] <= tx_empty_d && !tx_buffer_empty_flag;
            ev_q[2] <= modf_set || ovr_set || par_set;
            ev_q[3] <= flags[3] && !idle_q;
            ev_q[4] <= frame_done && !fifo_valid;
        end
    end
endmodule

// *** verification/spu_core_checker.sv ***
// Purpose: port assertions for spu_core
// Assumes: one clock, nrst synchronous active low
// Notes: bound from the bench top file
`timescale 1ns/1ps
module spu_core_checker
    import spu_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // controls
    input wire spu_cfg_t cfg,
    input wire logic [2:0] err_clr,
    // watched outputs
    input wire logic rx_buffer_full_flag,
    input wire logic mosi_o,
    input wire logic mosi_oe,
    input wire logic [3:0] slave_select_line_o,
    input wire logic [3:0] slave_select_line_oe,
    input wire spu_err_t err_q,
    input wire logic [3:0] irq_q,
    input wire logic [4:0] ev_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // ======================================================
    // select pins
    AST_MULTI_SEL_IN: assert property (
        cfg.mode == SPU_MULTI [*2] |-> !slave_select_line_oe[0])
        else $error("select zero driven in multi-master mode");
    AST_SINGLE_SEL_OUT: assert property (
        cfg.enable && cfg.mode == SPU_SINGLE [*3]
        |-> slave_select_line_oe == 4'hF)
        else $error("select lines not all driven");
    // slack of two cycles: mosi is flopped after the edge
    AST_IDLE_MOSI: assert property (
        cfg.enable && cfg.mode == SPU_SINGLE && mosi_oe
        && (slave_select_line_o ^ cfg.sel_pol) == 4'hF [*3]
        |-> mosi_o == cfg.idle_mosi)
        else $error("master-out not at idle level");
    // ======================================================
    // status, events, interrupts
    AST_RX_EVENT: assert property (
        $rose(rx_buffer_full_flag) |-> ev_q[0])
        else $error("no receive-full event");
    AST_RX_IRQ: assert property (
        rx_buffer_full_flag && cfg.irq_en[0] |-> ##[0:1] irq_q[0])
        else $error("no receive-full interrupt");
    AST_ERR_EVENT: assert property (
        $rose(err_q.ovr) || $rose(err_q.modf)
        |-> ev_q[2] || $past(ev_q[2]))
        else $error("no error event");
    AST_AUTO_STOP: assert property (
        cfg.clock_auto_stop_enable && !cfg.tx_only |-> !$rose(err_q.ovr))
        else $error("overrun raised with auto-stop on");
    AST_ERR_STICKY: assert property (
        err_q.ovr && !err_clr[1] |=> err_q.ovr)
        else $error("overrun flag lost without clear");
endmodule

// *** verification/spu_peer_model.sv ***
// Purpose: external SPI slave in mode 0
// Assumes: select active high on sel, msb first
// Notes: reply loaded at select, received bits in got
`timescale 1ns/1ps
module spu_peer_model (
    // serial pins
    input wire logic sck,
    input wire logic sel,
    input wire logic mosi,
    output logic miso,
    // data
    input wire logic [31:0] reply,
    output logic [31:0] got
);
    logic [31:0] sh = 32'h0;
    logic idle_lvl = 1'b0;
    initial got = 32'h0;
    always @(posedge sel) begin
        sh = reply;
        got = 32'h0;
    end
    // released line shows the inverse, never a stale bit
    always @(negedge sel) idle_lvl = ~sh[31];
    always @(posedge sck) if (sel) got = {got[30:0], mosi};
    always @(negedge sck) if (sel) sh = {sh[30:0], 1'b0};
    assign miso = sel ? sh[31] : idle_lvl;
endmodule

// *** verification/spu_core_bench.sv ***
// Purpose: self-checking bench for spu_core as master and three-wire slave
// Assumes: peer model in mode 0, brdiv 2
// Notes: frame timing taken from a cycle monitor
`timescale 1ns/1ps
module spu_core_bench
    import spu_pkg::*;
;
    // ======================================================
    // wiring
    logic clk = 1'b0, nrst = 1'b0, cmd_we = 1'b0, tx_valid = 1'b0;
    logic rx_ack = 1'b0, sel0_i = 1'b1, sel_p = 1'b0, sck_p = 1'b0;
    logic [2:0] err_clr = 3'h0;
    logic [31:0] tx_data = 32'h0, reply = 32'h0, rx_data, got;
    spu_cfg_t cfg = '0;
    spu_cmd_t cmd_wdata = '0;
    logic tx_ready, rx_full, sck_o, sck_oe, mosi_o, mosi_oe, tx_empty;
    logic idle_q, sck, sel, miso;
    logic sck_b = 1'b0;
    logic [3:0] ss_o, ss_oe, irq_q;
    logic [4:0] ev_q;
    spu_err_t err_q;
    int n_errors = 0, checks = 0, cyc = 0, ts = 0, t1 = 0, t2 = 0;
    int nr = 0, d0, n;
    bit ok;
    always #10 clk = ~clk;
    // bench clocks the pin while the unit does not drive it
    assign sck = sck_oe ? sck_o : sck_b;
    assign sel = ss_oe[0] & ~ss_o[0];
    spu_core i_spu_core (.clk(clk), .nrst(nrst), .cfg(cfg),
        .cmd_we(cmd_we), .cmd_sel(3'h0), .cmd_wdata(cmd_wdata),
        .err_clr(err_clr), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_data_q(rx_data),
        .rx_buffer_full_flag(rx_full), .rx_ack(rx_ack),
        .serial_clock_line_i(sck), .serial_clock_line_o(sck_o),
        .serial_clock_line_oe(sck_oe), .mosi_i(mosi_o),
        .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso), .miso_o(),
        .miso_oe(), .select_line_zero_i(sel0_i),
        .slave_select_line_o(ss_o), .slave_select_line_oe(ss_oe),
        .tx_buffer_empty_flag(tx_empty), .err_q(err_q),
        .idle_q(idle_q), .irq_q(irq_q), .ev_q(ev_q));
    spu_peer_model i_spu_peer_model (.sck(sck), .sel(sel),
        .mosi(mosi_o), .miso(miso), .reply(reply), .got(got));
    // select start and serial clock rises, in clk cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        sel_p <= sel;
        sck_p <= sck;
        if (sel && !sel_p) begin
            ts <= cyc;
            nr <= 0;
        end else if (sck && !sck_p) begin
            nr <= nr + 1;
            if (nr == 0) t1 <= cyc;
            if (nr == 1) t2 <= cyc;
        end
    end
    // ======================================================
    // tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    function automatic logic cond(input int k);
        case (k)
            0: return rx_full;
            1: return idle_q;
            2: return err_q.ovr;
            default: return err_q.modf;
        endcase
    endfunction
    task automatic wait_on(input int k);
        repeat (4000) if (cond(k) !== 1'b1) @(negedge clk);
        if (cond(k) !== 1'b1) begin
            n_errors++;
            $display("mismatch at %0t: wait %0d ran out", $time, k);
            complete_run();
        end
    endtask
    task automatic pulse(input logic [2:0] clr);
        @(negedge clk);
        rx_ack = 1'b1;
        err_clr = clr;
        @(negedge clk);
        rx_ack = 1'b0;
        err_clr = 3'h0;
    endtask
    task automatic push(input logic [31:0] w, input int lim);
        ok = 0;
        @(negedge clk);
        tx_data = w;
        tx_valid = 1'b1;
        repeat (lim) if (!ok) begin
            @(posedge clk);
            ok = (tx_ready === 1'b1);
        end
        @(negedge clk);
        tx_valid = 1'b0;
    endtask
    task automatic set_cmd(input logic [3:0] code, input logic lsb,
                           input logic [2:0] ckd);
        @(negedge clk);
        cmd_wdata.len_code = code;
        cmd_wdata.lsb_first = lsb;
        cmd_wdata.ck_dly = ckd;
        cmd_we = 1'b1;
        @(negedge clk);
        cmd_we = 1'b0;
    endtask
    function automatic logic [31:0] rev(input logic [31:0] v, input int l);
        rev = 32'h0;
        for (int i = 0; i < l; i++) rev[l - 1 - i] = v[i];
    endfunction
    task automatic frame(input logic [3:0] code, input logic lsb,
        input logic [2:0] ckd, input logic [31:0] w, input logic [31:0] r);
        int len;
        logic [31:0] m;
        len = code <= 4'h8 ? code + 8 : code == 4'h9 ? 20 :
              code == 4'hA ? 24 : 32;
        m = len == 32 ? 32'hFFFF_FFFF : (32'h1 << len) - 1;
        set_cmd(code, lsb, ckd);
        reply = r << (32 - len);
        push(w, 200);
        wait_on(0);
        check(nr, len);
        check(got & m, lsb ? rev(w & m, len) : w & m);
        check(rx_data, lsb ? rev(r & m, len) : r & m);
        pulse(3'h0);
        wait_on(1);
    endtask
    // ======================================================
    // sequence
    initial begin
        cfg.sel_pol = 4'hE;
        cfg.idle_mosi = 1'b1;
        cfg.irq_en = 4'hF;
        cmd_wdata.brdiv = 11'h002;
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        set_cmd(4'h0, 1'b0, 3'h0);
        check({30'h0, tx_empty, idle_q}, 32'h3);
        cfg.enable = 1'b1;
        repeat (4) @(negedge clk);
        check({24'h0, ss_oe, ss_o}, 32'hF1);
        for (int c = 0; c < 12; c++)
            frame(c[3:0], 1'b0, 3'h0, 32'hC3A5_96E1 ^ c, 32'h5A3C_E187 + c);
        d0 = t1 - ts;
        check(t2 - t1, 6);
        frame(4'h0, 1'b1, 3'h3, 32'h0000_00B1, 32'h0000_002D);
        check(t1 - ts - d0, 18);
        check({31'h0, mosi_o}, 32'h1);
        set_cmd(4'h0, 1'b0, 3'h0);
        push(32'h11, 200);
        push(32'h22, 200);
        wait_on(2);
        pulse(3'h2);
        wait_on(1);
        check({29'h0, err_q}, 32'h0);
        cfg.clock_auto_stop_enable = 1'b1;
        push(32'h33, 200);
        wait_on(0);
        n = 0;
        repeat (12) begin
            push(n, 1);
            if (ok) n++;
        end
        check(n, 8);
        repeat (8) begin
            pulse(3'h0);
            wait_on(0);
        end
        pulse(3'h0);
        wait_on(1);
        check({28'h0, tx_empty, err_q}, 32'h8);
        cfg.mode = SPU_MULTI;
        sel0_i = 1'b0;
        wait_on(3);
        check({31'h0, err_q.modf}, 32'h1);
        sel0_i = 1'b1;
        // let the select synchroniser drain before clearing
        repeat (3) @(negedge clk);
        pulse(3'h4);
        check({29'h0, err_q}, 32'h0);
        // three-wire slave, receives the idle-high loopback line
        cfg.mode = SPU_SLAVE;
        cfg.three_wire = 1'b1;
        // each slave clock phase lasts four bus clocks
        repeat (16) begin
            repeat (4) @(negedge clk);
            sck_b = ~sck_b;
        end
        wait_on(0);
        check(rx_data, 32'h0000_00FF);
        complete_run();
    end
endmodule

bind spu_core spu_core_checker i_spu_core_checker (.clk(clk), .nrst(nrst),
    .cfg(cfg), .err_clr(err_clr), .rx_buffer_full_flag(rx_buffer_full_flag),
    .mosi_o(mosi_o), .mosi_oe(mosi_oe),
    .slave_select_line_o(slave_select_line_o),
    .slave_select_line_oe(slave_select_line_oe), .err_q(err_q),
    .irq_q(irq_q), .ev_q(ev_q));
